// >>> logic/pwm_division_top.sv
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/10ps
// Function
// RULE_01 - The period select bit picks an input clock of the system clock over 2 (when 0) or over 4 (when 1).
// RULE_02 - A conversion period lasts 16384 clocks with 1-clock resolution, or 32768 clocks with 2-clock resolution.
// RULE_03 - Clock control bits 7 to 1 always read 1 and ignore writes.
// RULE_04 - The period select bit is write-only and its position always reads 1.
// RULE_05 - After reset the clock control register holds ones in bits 7 to 1 and a zero period select.
// RULE_06 - The 14-bit duty value takes its top 6 bits from the upper byte and its low 8 bits from the lower byte.
// RULE_07 - The duty value sets the total high time over one conversion period.
// RULE_08 - Software writes the lower duty byte first and the upper duty byte last.
// RULE_09 - A write to the upper byte moves both bytes into the generator at the next period start.
// RULE_10 - Both duty registers are write-only and read as all ones.
// RULE_11 - After reset the duty value is zero and the two unused upper bits are one.
// RULE_12 - Each conversion period is made of 64 consecutive sub-pulses.
// RULE_13 - High time per period equals duty plus 64, times half the input clock period.
// RULE_14 - Software routes the shared pin to this block, then picks the period, then loads the duty.
// RULE_15 - Extra high units are spread evenly so sub-pulses differ by at most one unit.
module pwm_division_top
  import pwm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [DAT_W-1:0] dat_i,
  output logic [DAT_W-1:0] dat_o,
  output logic ack_o,
  output logic pwm_o
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  pwm_if pif();

  logic req;
  logic [15:0] idx;
  logic wr_ok;
  logic ack_ff;
  logic [DAT_W-1:0] dat_ff;
  logic period_select_ff;
  logic [UPPER_W-1:0] duty_upper_ff;
  logic [LOWER_W-1:0] duty_lower_ff;
  logic pending_ff;
  logic sel_act_ff;
  logic [DUTY_W-1:0] duty_act_ff;
  logic [DUTY_W-1:0] staged;
  logic [DUTY_W-1:0] cnt_ff;
  logic wrap;
  logic [SUB_W-1:0] sub;
  logic [SUB_W-1:0] sub_rev;
  logic [POS_W-1:0] pos;
  logic extra;
  logic [8:0] width;
  logic high_now;
  logic pwm_ff;
  logic [14:0] hi_cnt_ff;
  logic [15:0] cyc_ff;
  logic [14:0] exp_high;

  // ------------------------------------------------------------------
  // Prescaler
  // ------------------------------------------------------------------

  // The divider follows the period choice now in force.
  assign pif.period_select = sel_act_ff;
  assign pif.restart = wrap;

  pwm_prescaler u_prescaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pif(pif)
  );

  // ------------------------------------------------------------------
  // Wishbone slave
  // ------------------------------------------------------------------

  // A request is one word; the index is the word address.
  assign req = cyc_i && stb_i;
  assign idx = adr_i[ADR_W-1:2];
  assign wr_ok = req && we_i && ack_ff && sel_i[0];

  // Acknowledge one cycle after the request, and drop it the cycle after.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req && !ack_ff;
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = dat_ff;

  // Read data is captured with the acknowledge and held while it stands.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_ff <= '0;
    end else if (req && !ack_ff) begin
      dat_ff <= '0;
      case (idx)
        IDX_CLOCK_CONTROL: begin
          dat_ff[7:0] <= WO_READ_VALUE; // [RULE_03] [RULE_04]
        end
        IDX_DUTY_UPPER, IDX_DUTY_LOWER: begin
          dat_ff[7:0] <= WO_READ_VALUE; // [RULE_10]
        end
        IDX_STATUS: begin
          dat_ff[ST_DUTY_LSB +: DUTY_W] <= duty_act_ff;
          dat_ff[ST_SEL_BIT] <= sel_act_ff;
          dat_ff[ST_PEND_BIT] <= pending_ff;
          dat_ff[ST_SUB_LSB +: SUB_W] <= sub;
        end
        default: begin
          dat_ff <= '0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------------

  // Only the period select bit is stored; the reserved bits are constant.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_select_ff <= CLOCK_CONTROL_RESET[PERIOD_SELECT_BIT]; // [RULE_05]
    end else if (wr_ok && idx == IDX_CLOCK_CONTROL) begin
      period_select_ff <= dat_i[PERIOD_SELECT_BIT]; // [RULE_01] [RULE_03]
    end
  end

  // Upper duty byte keeps six bits; the top two are never stored.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      duty_upper_ff <= DUTY_UPPER_RESET[UPPER_W-1:0]; // [RULE_11]
    end else if (wr_ok && idx == IDX_DUTY_UPPER) begin
      duty_upper_ff <= dat_i[UPPER_W-1:0]; // [RULE_06]
    end
  end

  // Lower duty byte holds the low eight bits.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      duty_lower_ff <= DUTY_LOWER_RESET; // [RULE_11]
    end else if (wr_ok && idx == IDX_DUTY_LOWER) begin
      duty_lower_ff <= dat_i[LOWER_W-1:0]; // [RULE_06]
    end
  end

  // The combined value loaded into the generator at the next period start once a transfer is armed.
  assign staged = {duty_upper_ff, duty_lower_ff}; // [RULE_06]

  // Upper byte write arms a transfer; a new write wins over the clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pending_ff <= 1'b0;
    end else if (wr_ok && idx == IDX_DUTY_UPPER) begin
      pending_ff <= 1'b1; // [RULE_09]
    end else if (wrap) begin
      pending_ff <= 1'b0;
    end
  end

  // The generator takes new data only at a period boundary.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      duty_act_ff <= DUTY_COMBINED_RESET[DUTY_W-1:0]; // [RULE_11]
    end else if (wrap && pending_ff) begin
      duty_act_ff <= staged; // [RULE_09]
    end
  end

  // The period choice also switches only at a boundary.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_act_ff <= CLOCK_CONTROL_RESET[PERIOD_SELECT_BIT];
    end else if (wrap) begin
      sel_act_ff <= period_select_ff; // [RULE_02]
    end
  end

  // ------------------------------------------------------------------
  // Waveform generator
  // ------------------------------------------------------------------

  // Unit counter: 64 sub-pulses of 256 units each.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
    end else if (pif.unit_en) begin
      cnt_ff <= cnt_ff + 14'h1; // [RULE_02] [RULE_12]
    end
  end

  assign wrap = pif.unit_en && cnt_ff == CNT_LAST;
  assign sub = cnt_ff[DUTY_W-1:POS_W];
  assign pos = cnt_ff[POS_W-1:0];

  // Bit-reversed sub-pulse number orders the extra units evenly.
  for (genvar i = 0; i < SUB_W; i++) begin : g_rev
    assign sub_rev[i] = sub[SUB_W-1-i];
  end

  // Each sub-pulse gets base+1 units, plus one when it is chosen.
  assign extra = sub_rev < duty_act_ff[SUB_W-1:0]; // [RULE_15]
  assign width = {1'b0, duty_act_ff[DUTY_W-1:SUB_W]} + 9'd1 + {8'h0, extra}; // [RULE_13]
  assign high_now = {1'b0, pos} < width; // [RULE_07] [RULE_12]

  // The pin is registered so it never glitches.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_ff <= 1'b0;
    end else if (pif.unit_en) begin
      pwm_ff <= high_now; // [RULE_07]
    end
  end

  assign pwm_o = pwm_ff;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------

  // High units counted since the period started.
  always_ff @(posedge clk_i) begin
    if (rst_i || wrap) begin
      hi_cnt_ff <= '0;
    end else if (pif.unit_en && high_now) begin
      hi_cnt_ff <= hi_cnt_ff + 15'd1;
    end
  end

  // System clocks since the period started.
  always_ff @(posedge clk_i) begin
    if (rst_i || wrap) begin
      cyc_ff <= '0;
    end else begin
      cyc_ff <= cyc_ff + 16'h1;
    end
  end

  // High total cannot exceed the whole period.
  assign exp_high = ({1'b0, duty_act_ff} + HIGH_OFFSET > PERIOD_UNITS) ?
                    PERIOD_UNITS : {1'b0, duty_act_ff} + HIGH_OFFSET;

  property p_unit_rate;
    @(posedge clk_i) disable iff (rst_i)
    (sel_act_ff && pif.unit_en && !wrap) |=> !pif.unit_en ##1 pif.unit_en;
  endproperty
  a_unit_rate: assert property (p_unit_rate) // [RULE_01]
    else $error("unit enable rate wrong for divide by four");

  property p_period_len;
    @(posedge clk_i) disable iff (rst_i)
    wrap |-> 32'(cyc_ff) == (sel_act_ff ? CONV_CLOCKS_SLOW : CONV_CLOCKS_FAST) - 1;
  endproperty
  a_period_len: assert property (p_period_len) // [RULE_02]
    else $error("conversion period length wrong");

  property p_ctrl_read;
    @(posedge clk_i) disable iff (rst_i)
    (req && !ack_ff && !we_i && idx == IDX_CLOCK_CONTROL) |=> ack_o && dat_o[7:0] == WO_READ_VALUE;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) // [RULE_03] [RULE_04]
    else $error("clock control read is not all ones");

  property p_reset_val;
    @(posedge clk_i) $fell(rst_i) |-> !period_select_ff && duty_act_ff == 14'h0 && staged == 14'h0;
  endproperty
  a_reset_val: assert property (p_reset_val) // [RULE_05] [RULE_11]
    else $error("reset values wrong");

  property p_lower_store;
    @(posedge clk_i) disable iff (rst_i)
    (wr_ok && idx == IDX_DUTY_LOWER) |=> staged[LOWER_W-1:0] == $past(dat_i[7:0]);
  endproperty
  a_lower_store: assert property (p_lower_store) // [RULE_06]
    else $error("lower duty byte not stored");

  property p_high_total;
    @(posedge clk_i) disable iff (rst_i)
    wrap |-> hi_cnt_ff + 15'(high_now) == exp_high;
  endproperty
  a_high_total: assert property (p_high_total) // [RULE_07] [RULE_13]
    else $error("high time over the period wrong");

  property p_transfer;
    @(posedge clk_i) disable iff (rst_i)
    (wrap && pending_ff) |=> duty_act_ff == $past(staged);
  endproperty
  a_transfer: assert property (p_transfer) // [RULE_09]
    else $error("duty not transferred at period start");

  property p_duty_read;
    @(posedge clk_i) disable iff (rst_i)
    (req && !ack_ff && !we_i && (idx == IDX_DUTY_UPPER || idx == IDX_DUTY_LOWER))
      |=> dat_o == 32'h0000_00ff;
  endproperty
  a_duty_read: assert property (p_duty_read) // [RULE_10]
    else $error("duty register read is not all ones");

  property p_sub_step;
    @(posedge clk_i) disable iff (rst_i)
    (pif.unit_en && pos == 8'hff) |=> sub == $past(sub) + 6'h1;
  endproperty
  a_sub_step: assert property (p_sub_step) // [RULE_12]
    else $error("sub-pulse did not advance after 256 units");

  property p_spread;
    @(posedge clk_i) disable iff (rst_i)
    width - 9'({1'b0, duty_act_ff[DUTY_W-1:SUB_W]}) inside {9'd1, 9'd2};
  endproperty
  a_spread: assert property (p_spread) // [RULE_15]
    else $error("sub-pulse width outside base range");

endmodule

// >>> shared/pwm_pkg.sv
package pwm_pkg;

  // ------------------------------------------------------------------
  // Bus geometry.
  // ------------------------------------------------------------------
  localparam int unsigned ADR_W = 18;
  localparam int unsigned DAT_W = 32;

  // Register indices; the byte address is four times the index.
  localparam logic [15:0] IDX_CLOCK_CONTROL = 16'hffd0;
  localparam logic [15:0] IDX_DUTY_UPPER = 16'hffd1;
  localparam logic [15:0] IDX_DUTY_LOWER = 16'hffd2;
  localparam logic [15:0] IDX_STATUS = 16'hffd3;

  // ------------------------------------------------------------------
  // Reset and read-back values.
  // ------------------------------------------------------------------
  localparam logic [7:0] CLOCK_CONTROL_RESET = 8'hfe;
  localparam logic [7:0] DUTY_UPPER_RESET = 8'hc0;
  localparam logic [7:0] DUTY_LOWER_RESET = 8'h00;
  localparam logic [15:0] DUTY_COMBINED_RESET = 16'hc000;
  localparam logic [7:0] WO_READ_VALUE = 8'hff;

  // ------------------------------------------------------------------
  // Field layout.
  // ------------------------------------------------------------------
  localparam int unsigned PERIOD_SELECT_BIT = 0;
  localparam int unsigned DUTY_W = 14;
  localparam int unsigned UPPER_W = 6;
  localparam int unsigned LOWER_W = 8;
  localparam int unsigned SUB_W = 6;
  localparam int unsigned POS_W = 8;
  localparam int unsigned ST_DUTY_LSB = 0;
  localparam int unsigned ST_SEL_BIT = 14;
  localparam int unsigned ST_PEND_BIT = 15;
  localparam int unsigned ST_SUB_LSB = 16;

  // ------------------------------------------------------------------
  // Timing, in system clocks and in half input clock units.
  // ------------------------------------------------------------------
  localparam int unsigned CONV_CLOCKS_FAST = 16384;
  localparam int unsigned CONV_CLOCKS_SLOW = 32768;
  localparam logic [14:0] HIGH_OFFSET = 15'd64;
  localparam logic [14:0] PERIOD_UNITS = 15'd16384;
  localparam logic [13:0] CNT_LAST = 14'h3fff;

endpackage

// >>> shared/pwm_if.sv
`timescale 1ns/10ps
// Link between the register side and the clock prescaler.
interface pwm_if;
  logic period_select;
  logic restart;
  logic unit_en;

  modport ctl (output period_select, output restart, input unit_en);
  modport div (input period_select, input restart, output unit_en);
endinterface

// >>> logic/pwm_prescaler.sv
`timescale 1ns/10ps
module pwm_prescaler
  import pwm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  pwm_if.div pif
);

  logic [1:0] div_ff;

  // Free divider, realigned at each period start so periods stay exact.
  always_ff @(posedge clk_i) begin
    if (rst_i || pif.restart) begin
      div_ff <= 2'h0;
    end else begin
      div_ff <= div_ff + 2'h1;
    end
  end

  // One unit is half an input clock: every clock for /2, every second for /4.
  assign pif.unit_en = pif.period_select ? div_ff[0] : 1'b1; // [RULE_01]

endmodule

// >>> test/pwm_lowpass_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Averaging filter that stands in for the external low-pass stage.
// ----------------------------------------------------------------
// It integrates the waveform over a window while en_i is high.
// It also counts the sub-pulse starts and the shortest and longest whole high runs.
module pwm_lowpass_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pwm_i,
  input wire logic en_i,
  output logic [15:0] high_cnt_o,
  output logic [15:0] rise_cnt_o,
  output logic [15:0] run_min_o,
  output logic [15:0] run_max_o
);
  logic en_q;
  logic prev_q;
  logic run_ok;
  logic [15:0] run_len;

  // The first sample of a window restarts every count; later samples accumulate.
  always_ff @(posedge clk_i) begin
    prev_q <= pwm_i;
    en_q <= en_i & ~rst_i;
    if (en_i && !en_q) begin
      high_cnt_o <= 16'(pwm_i);
      rise_cnt_o <= 16'(pwm_i && !prev_q);
      run_ok <= pwm_i && !prev_q;
      run_len <= 16'h0001;
      run_min_o <= 16'hffff;
      run_max_o <= 16'h0000;
    end else if (en_i) begin
      high_cnt_o <= high_cnt_o + 16'(pwm_i);
      if (pwm_i && !prev_q) begin
        rise_cnt_o <= rise_cnt_o + 16'h0001;
        run_ok <= 1'b1;
        run_len <= 16'h0001;
      end else if (pwm_i) begin
        run_len <= run_len + 16'h0001;
      end else if (prev_q && run_ok) begin
        // Only runs that began inside the window are judged, so a cut run is not counted.
        if (run_len < run_min_o) begin
          run_min_o <= run_len;
        end
        if (run_len > run_max_o) begin
          run_max_o <= run_len;
        end
      end
    end
  end
endmodule

// >>> test/tb.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin \
  n_compared++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end
module tb
  import pwm_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus signals and the two blocks.
  // ----------------------------------------------------------------
  localparam logic [17:0] A_CTRL = {IDX_CLOCK_CONTROL, 2'b00};
  localparam logic [17:0] A_UP = {IDX_DUTY_UPPER, 2'b00};
  localparam logic [17:0] A_LO = {IDX_DUTY_LOWER, 2'b00};
  localparam logic [17:0] A_STAT = {IDX_STATUS, 2'b00};
  localparam logic [17:0] A_NONE = 18'h3ff60;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [17:0] adr = 18'h00000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] dat_o;
  logic ack_o;
  logic pwm_o;
  logic en = 1'b0;
  logic [15:0] high_cnt, rise_cnt, run_min, run_max;
  logic [31:0] q;
  int error_cnt = 0;
  int n_compared = 0;

  pwm_division_top i_pwm_division_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .pwm_o(pwm_o));
  pwm_lowpass_model i_pwm_lowpass_model (.clk_i(clk_i), .rst_i(rst_i), .pwm_i(pwm_o), .en_i(en),
    .high_cnt_o(high_cnt), .rise_cnt_o(rise_cnt), .run_min_o(run_min), .run_max_o(run_max));

  // The clock toggles every 12.5 ns, half of its 25 ns period.
  always #12.5 clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // Bus, measurement and closing tasks.
  // ----------------------------------------------------------------
  // One classic cycle: hold the request until ack is sampled high, then idle one cycle.
  // Only the watchdog ends a wait for an acknowledge that never comes.
  task automatic wb(input logic w, input logic [17:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] r);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  // Polls the status until the armed load has reached the generator, bounded by 12000 polls of 3 clocks, just over one slow period.
  task automatic wait_load();
    int i;
    for (i = 0; i < 12000; i++) begin
      wb(1'b0, A_STAT, 32'h0, 4'h1, q);
      if (q[15] === 1'b0) break;
    end
    if (i == 12000) error_cnt++;
  endtask

  // Any window one period long holds exactly one period's worth of a steady waveform.
  task automatic measure(input int n);
    en <= 1'b1;
    repeat (n) @(posedge clk_i);
    en <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Register table: write, address, data, expected read, read mask.
  // ----------------------------------------------------------------
  typedef struct {logic w; logic [17:0] a; logic [31:0] d; logic [31:0] e; logic [31:0] m;} row_s;
  row_s rows[11] = '{
    '{1'b0, A_STAT, 32'h0, 32'h0, 32'h0000ffff},
    '{1'b0, A_CTRL, 32'h0, 32'hff, 32'hffffffff},
    '{1'b1, A_CTRL, 32'h00, 32'h0, 32'h0},
    '{1'b0, A_CTRL, 32'h0, 32'hff, 32'hffffffff},
    '{1'b1, A_CTRL, 32'h02, 32'h0, 32'h0},
    '{1'b0, A_CTRL, 32'h0, 32'hff, 32'hffffffff},
    '{1'b1, A_LO, 32'h34, 32'h0, 32'h0},
    '{1'b0, A_LO, 32'h0, 32'hff, 32'hffffffff},
    '{1'b1, A_UP, 32'h12, 32'h0, 32'h0},
    '{1'b0, A_UP, 32'h0, 32'hff, 32'hffffffff},
    '{1'b0, A_NONE, 32'h0, 32'h0, 32'hffffffff}};

  // Watchdog sized above the roughly 82000 cycles that the sequence needs.
  initial begin
    repeat (99000) @(posedge clk_i);
    error_cnt++;
    results();
  end

  // Main sequence: table loop, then the waveform and reset cases.
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b1, A_NONE, 32'haa, 4'h1, q);
    foreach (rows[i]) begin
      wb(rows[i].w, rows[i].a, rows[i].d, 4'h1, q);
      if (!rows[i].w) `CHK(q & rows[i].m, rows[i].e)
    end
    // Lower then upper was just written, so 0x1234 is armed in the fast mode.
    wait_load();
    `CHK(q[15:0], 16'h1234)
    measure(CONV_CLOCKS_FAST);
    `CHK(high_cnt, 16'd4724)
    `CHK(rise_cnt, 16'd64)
    `CHK({run_min, run_max}, {16'd73, 16'd74})
    // Slow mode, with a lower byte write lacking its byte select that must be ignored.
    wb(1'b1, A_CTRL, 32'h01, 4'h1, q);
    wb(1'b1, A_LO, 32'h5c, 4'h1, q);
    wb(1'b1, A_LO, 32'h77, 4'h0, q);
    wb(1'b1, A_UP, 32'h0a, 4'h1, q);
    wait_load();
    `CHK(q[15:0], 16'h4a5c)
    measure(CONV_CLOCKS_SLOW);
    `CHK(high_cnt, 16'd5432)
    `CHK(rise_cnt, 16'd64)
    `CHK({run_min, run_max}, {16'd84, 16'd86})
    // A second reset in mid-run restores the fast mode and a zero duty.
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, A_STAT, 32'h0, 4'h1, q);
    `CHK(q[15:0], 16'h0000)
    wb(1'b0, A_CTRL, 32'h0, 4'h1, q);
    `CHK(q, 32'h000000ff)
    results();
  end
endmodule
